// file: shared/swir_pkg.sv
/*
  Shared constants, types and timing for the single-wire identity slave.
  Assumes one 250 MHz clock and an open-drain line sampled synchronously.
*/
// Functional notes
// - Command is exactly eight bits; all eight are taken before acting.
// - Identity read 33h sends family, serial, then check byte, one per slot.
// - Search F0h walks identifier bits LSB first, three slots per bit.
// - Search sends the true bit, then the inverted bit.
// - Third search slot mismatch makes the device drop out silently.
// - Select 55h, address-all CCh and unknown commands leave device silent.
// - Build option selects a variant answering after 55h and CCh.
// - Master starts every signal; device starts only presence after reset.
// - After reset release, wait presence-wait time, then drive presence low.
// - Each slot carries one bit; write to device, read from device.
// - Each falling edge restarts the device slot timer.
// - Reading zero, device drives low until its timer ends; one, never.
// - Line low longer than 120 us is taken as a bus reset.
// - Presence only after reset: wait 15-60 us, low 60-240 us.
package swir_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int CLK_NS      = 4;
  localparam int NS_PER_US   = 1000;
  localparam int CNT_W       = 16;

  // Times in microseconds
  localparam int RST_DET_US  = 120;
  localparam int PWAIT_US    = 30;
  localparam int PLOW_US     = 120;
  localparam int RHOLD_US    = 15;
  localparam int WSAMP_US    = 30;

  // Least times round up, the read hold (a longest time) rounds down
  localparam int RST_DET_CYC = (RST_DET_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
  localparam int PWAIT_CYC   = (PWAIT_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
  localparam int PLOW_CYC    = (PLOW_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
  localparam int WSAMP_CYC   = (WSAMP_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
  localparam logic [CNT_W-1:0] RHOLD_CYC =
    CNT_W'((RHOLD_US * NS_PER_US) / CLK_NS);

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] CMD_READ_ID = 8'h33;
  localparam logic [7:0] CMD_SEARCH  = 8'hf0;
  localparam logic [7:0] CMD_SELECT  = 8'h55;
  localparam logic [7:0] CMD_ALL     = 8'hcc;

  localparam logic [6:0] CMD_LAST    = 7'h07;
  localparam logic [6:0] ID_LAST     = 7'h3f;

  localparam logic [1:0] PH_TRUE     = 2'h0;
  localparam logic [1:0] PH_INV      = 2'h1;
  localparam logic [1:0] PH_WRITE    = 2'h2;

  typedef enum logic [2:0] {
    st_silent,
    st_rst_low,
    st_pres_wait,
    st_pres_low,
    st_cmd,
    st_send,
    st_search
  } swir_state_t;

  // Identifier; family code sits in the low bits and leaves first
  typedef struct packed {
    logic [7:0]  crc;
    logic [47:0] serial;
    logic [7:0]  family;
  } swir_rom_t;

endpackage

// file: src/swir_timer.sv
/*
  Slot timing generator: counts clock cycles since the last restart.
  Assumes the caller restarts it on each falling edge of the line.
*/
`timescale 1ns/10ps
module swir_timer import swir_pkg::*; #(
  parameter int W = CNT_W
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  // Control
  input  wire logic         i_restart,
  // Elapsed cycles, saturating
  output logic      [W-1:0] o_count
);

  // Saturation keeps long idle periods from wrapping into false matches
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_count <= '1;
    end else if (i_restart) begin
      o_count <= '0;
    end else if (o_count != '1) begin
      o_count <= o_count + W'(1);
    end
  end

  a_timer_runs: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_restart ##1 !i_restart [*2]) |=> o_count == W'(2))
    else $error("slot timer does not count from restart");

endmodule

// file: src/swir_slave.sv
/*
  Device end of the single-wire identity link: reset/presence, slot timing,
  command byte, identity read-out and bitwise tree search.
  Assumes i_line is already synchronous to i_clock; the wire is resolved
  outside from o_line_oe (open drain, low only).
*/
`timescale 1ns/10ps
module swir_slave import swir_pkg::*; #(
  parameter int unsigned RST_DET     = RST_DET_CYC,
  parameter int unsigned PWAIT       = PWAIT_CYC,
  parameter int unsigned PLOW        = PLOW_CYC,
  parameter int unsigned WSAMP       = WSAMP_CYC,
  parameter bit          ALT_VARIANT = 1'b0
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Identifier contents
  input  wire swir_rom_t   i_rom,
  // Open-drain line
  input  wire logic        i_line,
  output logic             o_line_out,
  output logic             o_line_oe,
  // Observation
  output logic       [7:0] o_cmd
);

  ////////////////////////////////////////////////////////////////////////////
  // Edges and timer
  logic               line_q;
  logic [CNT_W-1:0]   cnt;
  logic               restart;
  swir_state_t        state_q;
  logic [6:0]         bits_q;
  logic [1:0]         phase_q;
  logic [7:0]         cmd_q;
  logic               slot_q;
  logic               drive_q;

  wire fall = line_q & ~i_line;
  wire rise = ~line_q & i_line;

  wire pwait_hit = (state_q == st_pres_wait) && (cnt == CNT_W'(PWAIT));
  wire plow_hit  = (state_q == st_pres_low) && (cnt == CNT_W'(PLOW));

  // Own presence drive must not look like a master reset
  wire rst_hit = !i_line && (cnt == CNT_W'(RST_DET)) &&
                 (state_q != st_pres_low);

  assign restart = fall | ((state_q == st_rst_low) && rise) | pwait_hit;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      line_q <= 1'b1;
    end else begin
      line_q <= i_line;
    end
  end

  swir_timer #(
    .W         (CNT_W)
  ) u_timer (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_restart (restart),
    .o_count   (cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Slot classification
  wire read_slot  = (state_q == st_send) ||
                    ((state_q == st_search) && (phase_q != PH_WRITE));
  wire write_slot = (state_q == st_cmd) ||
                    ((state_q == st_search) && (phase_q == PH_WRITE));

  wire id_bit = i_rom[bits_q[5:0]];
  wire tx_bit = (phase_q == PH_INV && state_q == st_search) ? ~id_bit
                                                            : id_bit;

  wire wsample = slot_q && write_slot && (cnt == CNT_W'(WSAMP));
  wire rend    = slot_q && read_slot && (cnt == RHOLD_CYC);
  wire [7:0] cmd_d = {i_line, cmd_q[7:1]};

  function automatic swir_state_t decode(input logic [7:0] c);
    unique case (c)
      CMD_READ_ID: decode = st_send;
      CMD_SEARCH:  decode = st_search;
      CMD_SELECT,
      CMD_ALL:     decode = ALT_VARIANT ? st_send : st_silent;
      default:     decode = st_silent;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Slot in progress: one bit per slot
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      slot_q <= 1'b0;
    end else if (rst_hit || wsample || rend) begin
      slot_q <= 1'b0;
    end else if (fall && (read_slot || write_slot)) begin
      slot_q <= 1'b1;
    end
  end

  // Line pulldown: presence pulse and zero read bits only
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      drive_q <= 1'b0;
    end else if (rst_hit || rend || plow_hit) begin
      drive_q <= 1'b0;
    end else if (pwait_hit) begin
      drive_q <= 1'b1;
    end else if (fall && read_slot && !slot_q && !tx_bit) begin
      drive_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_q <= st_silent;
      bits_q  <= '0;
      phase_q <= PH_TRUE;
      cmd_q   <= '0;
    end else if (rst_hit) begin
      state_q <= st_rst_low;
      bits_q  <= '0;
      phase_q <= PH_TRUE;
    end else begin
      unique case (state_q)
        st_silent: begin
          state_q <= st_silent;
        end
        st_rst_low: begin
          if (rise) begin
            state_q <= st_pres_wait;
          end
        end
        st_pres_wait: begin
          if (pwait_hit) begin
            state_q <= st_pres_low;
          end
        end
        st_pres_low: begin
          if (plow_hit) begin
            state_q <= st_cmd;
            bits_q  <= '0;
          end
        end
        st_cmd: begin
          if (wsample) begin
            cmd_q  <= cmd_d;
            bits_q <= bits_q + 7'h1;
            if (bits_q == CMD_LAST) begin
              state_q <= decode(cmd_d);
              bits_q  <= '0;
            end
          end
        end
        st_send: begin
          if (rend) begin
            bits_q <= bits_q + 7'h1;
            if (bits_q == ID_LAST) begin
              state_q <= st_silent;
            end
          end
        end
        st_search: begin
          if (rend && phase_q == PH_TRUE) begin
            phase_q <= PH_INV;
          end else if (rend && phase_q == PH_INV) begin
            phase_q <= PH_WRITE;
          end else if (wsample) begin
            phase_q <= PH_TRUE;
            bits_q  <= bits_q + 7'h1;
            if (i_line != id_bit || bits_q == ID_LAST) begin
              state_q <= st_silent;
            end
          end
        end
        default: begin
          state_q <= st_silent;
        end
      endcase
    end
  end

  assign o_line_out = 1'b0;
  assign o_line_oe  = drive_q;
  assign o_cmd      = cmd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_pres_start;
    state_q == st_pres_wait ##1 state_q == st_pres_low;
  endsequence

  sequence s_search_miss;
    state_q == st_search && wsample && (i_line != id_bit);
  endsequence

  a_presence_hold: assert property (s_pres_start |-> o_line_oe [*8])
    else $error("presence pulse not held low");

  a_presence_cause: assert property (
    $rose(o_line_oe) && state_q == st_pres_low
      |-> $past(state_q) == st_pres_wait)
    else $error("presence pulse without reset");

  a_silent_quiet: assert property (
    state_q == st_silent && $past(state_q) == st_silent |-> !o_line_oe)
    else $error("silent device drives the line");

  a_cmd_eight_bits: assert property (
    $past(state_q) == st_cmd && state_q != st_cmd && state_q != st_rst_low
      |-> $past(bits_q) == CMD_LAST && $past(wsample))
    else $error("command acted on before eight bits");

  a_read_release: assert property (
    o_line_oe && read_slot |-> cnt <= RHOLD_CYC)
    else $error("read zero held past timer end");

  a_search_drop: assert property (s_search_miss |=> state_q == st_silent
    ##1 !o_line_oe)
    else $error("search mismatch did not drop out");

  a_search_polarity: assert property (
    $rose(o_line_oe) && state_q == st_search
      |-> (phase_q == PH_TRUE) == !id_bit)
    else $error("search bit polarity wrong");

  a_read_id_bit: assert property (
    $rose(o_line_oe) && state_q == st_send |-> !id_bit)
    else $error("identity read drives a one bit");

  a_reset_abort: assert property (rst_hit |=> state_q == st_rst_low
    && !o_line_oe)
    else $error("long low did not reset the device");

endmodule

// file: sim/swir_master_model.sv
/*
  Bus master model with the line pullup, for the single-wire identity slave.
  Assumes the bench calls its tasks; it drives at falling clock edges.
*/
`timescale 1ns/10ps
module swir_master_model #(
  parameter int RST_LOW = 4100,
  parameter int SLOT    = 3800,
  parameter int WSLOT   = 120,
  parameter int WLOW0   = 60
) (
  // Clock and device pulldown
  input  wire logic i_clock,
  input  wire logic i_dev_oe,
  // Resolved wire
  output logic      o_line
);
  logic pull_q = 1'b0;

  // Pullup: the wire is low only while some party pulls it
  assign o_line = ~(pull_q | i_dev_oe);

  task automatic hold(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  // Reset pulse, then measure presence delay and width in cycles
  task automatic bus_reset(output int dly, output int wid);
    dly = 1;
    wid = 0;
    @(negedge i_clock);
    pull_q = 1'b1;
    hold(RST_LOW);
    pull_q = 1'b0;
    hold(1);
    while (o_line && dly < 500) begin
      hold(1);
      dly++;
    end
    while (!o_line && wid < 500) begin
      hold(1);
      wid++;
    end
    hold(60);
  endtask

  task automatic write_bit(input logic b);
    @(negedge i_clock);
    pull_q = 1'b1;
    hold(b ? 4 : WLOW0);
    pull_q = 1'b0;
    // Write slots end at the device sample, so they may be short
    hold(WSLOT - (b ? 4 : WLOW0));
  endtask

  // Late flags a device still pulling at the end of the slot
  task automatic read_bit(output logic b, output logic late);
    @(negedge i_clock);
    pull_q = 1'b1;
    hold(3);
    pull_q = 1'b0;
    hold(SLOT - 1000);
    b = o_line;
    hold(990);
    late = ~o_line;
  endtask
endmodule

// file: sim/swir_slave_tb_top.sv
/*
  Bench for the single-wire identity slave: reset, presence and commands.
  Assumes the master model drives the wire; slave timings are shortened.
*/
`timescale 1ns/10ps
module swir_slave_tb_top import swir_pkg::*; ;
  // Reset detect must outlast the fixed read-zero hold of 3750 cycles
  localparam int RST_DET = 4000;
  localparam int RST_LOW = RST_DET + 100;
  localparam int WSLOT   = 120;
  localparam int PWAIT   = 40;
  localparam int PLOW    = 60;
  localparam int WSAMP   = 30;

  logic       i_clock   = 1'b0;
  logic       i_rst     = 1'b1;
  logic       line;
  logic       oe;
  logic       dout;
  logic [7:0] cmd;
  logic       line_alt;
  logic       oe_alt;
  logic       dout_alt;
  logic [7:0] cmd_alt;
  int         n_errors  = 0;
  int         cmp_count = 0;
  // Arbitrary identifier contents
  swir_rom_t  rom = '{crc: 8'h5a, serial: 48'h0123456789ab, family: 8'h3c};

  swir_slave #(.RST_DET(RST_DET), .PWAIT(PWAIT), .PLOW(PLOW),
    .WSAMP(WSAMP), .ALT_VARIANT(1'b0)) uut (.i_clock(i_clock),
    .i_rst(i_rst), .i_rom(rom), .i_line(line), .o_line_out(dout),
    .o_line_oe(oe), .o_cmd(cmd));
  swir_master_model #(.RST_LOW(RST_LOW), .WSLOT(WSLOT)) mst (
    .i_clock(i_clock), .i_dev_oe(oe), .o_line(line));

  // Answering variant on a wire of its own
  swir_slave #(.RST_DET(RST_DET), .PWAIT(PWAIT), .PLOW(PLOW),
    .WSAMP(WSAMP), .ALT_VARIANT(1'b1)) uut_alt (.i_clock(i_clock),
    .i_rst(i_rst), .i_rom(rom), .i_line(line_alt),
    .o_line_out(dout_alt), .o_line_oe(oe_alt), .o_cmd(cmd_alt));
  swir_master_model #(.RST_LOW(RST_LOW), .WSLOT(WSLOT)) mst_alt (
    .i_clock(i_clock), .i_dev_oe(oe_alt), .o_line(line_alt));

  initial begin
    forever #2 i_clock = ~i_clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic reset_ok();
    int d;
    int w;
    mst.bus_reset(d, w);
    check("pres_dly", 8'(d >= PWAIT && d <= PWAIT + 4), 8'h01);
    check("pres_wid", 8'(w >= PLOW && w <= PLOW + 4), 8'h01);
    check("drive_val", {7'h00, dout}, 8'h00);
  endtask

  task automatic send_cmd(input logic [7:0] c);
    for (int i = 0; i < 8; i++) begin
      mst.write_bit(c[i]);
    end
    check("cmd", cmd, c);
  endtask

  task automatic rd(input string what, input logic exp);
    logic b;
    logic late;
    mst.read_bit(b, late);
    check(what, {7'h00, b}, {7'h00, exp});
    check("release", {7'h00, late}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Partial read, then cut short by the next reset
  task automatic t_read_id();
    reset_ok();
    send_cmd(CMD_READ_ID);
    for (int i = 0; i < 4; i++) begin
      rd("id_bit", rom.family[i]);
    end
    $display("Test read_id done");
  endtask

  // Bit 0 matches, bit 1 is written opposite and the device drops out
  task automatic t_search();
    reset_ok();
    send_cmd(CMD_SEARCH);
    rd("true0", rom.family[0]);
    rd("inv0", ~rom.family[0]);
    mst.write_bit(rom.family[0]);
    rd("true1", rom.family[1]);
    rd("inv1", ~rom.family[1]);
    mst.write_bit(~rom.family[1]);
    rd("dropped", 1'b1);
    $display("Test search done");
  endtask

  task automatic t_unsup();
    reset_ok();
    send_cmd(CMD_ALL);
    rd("silent", 1'b1);
    $display("Test unsupported done");
  endtask

  // Variant answers read slots with the identifier after select
  task automatic t_alt();
    int   d;
    int   w;
    logic b;
    logic late;
    mst_alt.bus_reset(d, w);
    check("alt_pres", 8'(d >= PWAIT && d <= PWAIT + 4), 8'h01);
    check("alt_wid", 8'(w >= PLOW && w <= PLOW + 4), 8'h01);
    for (int i = 0; i < 8; i++) begin
      mst_alt.write_bit(CMD_SELECT[i]);
    end
    check("alt_cmd", cmd_alt, CMD_SELECT);
    for (int i = 0; i < 2; i++) begin
      mst_alt.read_bit(b, late);
      check("alt_bit", {7'h00, b}, {7'h00, rom.family[i]});
      check("alt_release", {7'h00, late}, 8'h00);
    end
    check("alt_drive_val", {7'h00, dout_alt}, 8'h00);
    $display("Test variant done");
  endtask

  initial begin
    repeat (90000) @(posedge i_clock);
    n_errors++;
    $display("Error watchdog expected done seen timeout");
    end_sim();
  end

  initial begin
    repeat (5) @(posedge i_clock);
    @(negedge i_clock);
    i_rst = 1'b0;
    t_read_id();
    t_search();
    t_unsup();
    t_alt();
    end_sim();
  end
endmodule
